// >>> src/usp_map.vh
// Register offsets, field positions, reset values and timing constants of the serial port.
`ifndef USP_MAP_VH
`define USP_MAP_VH
`define USP_OFF_CTRL      12'h000
`define USP_OFF_DATA      12'h004
`define USP_OFF_RELOAD    12'h008
`define USP_OFF_TMRCFG    12'h00c
`define USP_OFF_STATUS    12'h010
`define USP_OFF_MASK      12'h014
`define USP_CTRL_MODE9    7
`define USP_CTRL_ONE      6
`define USP_CTRL_MCE      5
`define USP_CTRL_REN      4
`define USP_CTRL_TB8      3
`define USP_CTRL_RB8      2
`define USP_CTRL_TDONE    1
`define USP_CTRL_RDONE    0
`define USP_TCFG_RUN      3
`define USP_SRC_DIV4      3'h0
`define USP_SRC_DIV12     3'h1
`define USP_SRC_DIV48     3'h2
`define USP_SRC_EXT8      3'h3
`define USP_SRC_PIN       3'h4
`define USP_RST_CTRL      8'h40
`define USP_RST_RELOAD    8'h00
`define USP_RST_TMRCFG    4'h0
`define USP_PRESC_DIV4    6'd4
`define USP_PRESC_DIV12   6'd12
`define USP_PRESC_DIV48   6'd48
`define USP_EXT_DIV       4'h8
`define USP_FRAME8_BITS   4'd10
`define USP_FRAME9_BITS   4'd11
`endif

// >>> src/usp_reload_cnt.v
// Eight-bit auto-reload counter that pulses on overflow, with a forced reload.
`timescale 1ns/100ps
module usp_reload_cnt #(
   parameter WIDTH = 8
) (
   input  wire             sys_clk,
   input  wire             reset_n,
   input  wire             tick,
   input  wire             force_load,
   input  wire [WIDTH-1:0] reload,
   output reg              ovf
);
   reg [WIDTH-1:0] cnt_r;

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= {WIDTH{1'b0}};
         ovf   <= 1'b0;
      end else if (force_load) begin
         cnt_r <= reload;
         ovf   <= 1'b0;
      end else if (tick) begin
         if (&cnt_r) begin
            cnt_r <= reload;
            ovf   <= 1'b1;
         end else begin
            cnt_r <= cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
            ovf   <= 1'b0;
         end
      end else begin
         ovf <= 1'b0;
      end
   end
endmodule

// >>> src/usp_sync.v
// Two-flop synchroniser for an asynchronous level.
`timescale 1ns/100ps
module usp_sync #(
   parameter INIT = 1'b1
) (
   input  wire sys_clk,
   input  wire reset_n,
   input  wire din,
   output reg  dout
);
   reg meta_r;

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= INIT;
         dout   <= INIT;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule

// >>> src/usp_uart.v
// Full-duplex serial port with timer-based baud generation and an AXI4-Lite register slave.
//
// Function
// R01 - Full-duplex port, 8-bit and 9-bit variable modes.
// R02 - Received byte buffered while next one arrives.
// R03 - Data location write loads transmit register.
// R04 - Data location read returns receive buffer.
// R05 - Done flags request interrupt when enabled.
// R06 - Done flags stay set until software clears.
// R07 - Baud from eight-bit auto-reload timer.
// R08 - Transmit uses low count, receive a copy.
// R09 - Both counter overflows divided by two.
// R10 - Receive copy runs with timer, same reload.
// R11 - Start bit forces receive counter reload.
// R12 - Software picks reload for twice baud.
// R13 - Timer clock from divided system or external.
// R14 - Timer clock independent of system clock.
// R15 - Ten-bit frame, start, eight LSB-first, stop.
// R16 - Ninth bit sent and stored in 9-bit mode.
// R17 - Load only if flag clear and check passes.
// R18 - Transmit done set at stop bit start.
// R19 - Receiver samples near mid bit.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "usp_map.vh"
module usp_uart #(
   parameter CNT_W = 8
) (
   input  wire        sys_clk,
   input  wire        reset_n,
   input  wire        ext_osc_clk,
   input  wire        timer1_external_input,
   input  wire        rx_pin,
   output reg         tx_pin,
   output wire        irq,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);
   localparam TX_IDLE  = 3'b001;
   localparam TX_SHIFT = 3'b010;
   localparam TX_STOP  = 3'b100;
   localparam RX_IDLE  = 3'b001;
   localparam RX_BITS  = 3'b010;
   localparam RX_DONE  = 3'b100;
   localparam [7:0] CTRL_RST = `USP_RST_CTRL;

   // Control, buffers and interrupt registers.
   reg        mode9_r;
   reg        mce_r;
   reg        ren_r;
   reg        tb8_r;
   reg        rb8_r;
   reg        tdone_r;
   reg        rdone_r;
   reg [7:0]  rx_buf_r;
   reg [7:0]  reload_r;
   reg [3:0]  tmrcfg_r;
   reg [1:0]  irq_mask_r;

   // AXI handshake state.
   reg        aw_held_r;
   reg [11:0] aw_addr_r;
   reg        w_held_r;
   reg [31:0] w_data_r;
   reg [3:0]  w_strb_r;

   wire       sync_rx;
   wire       sync_xo;
   wire       sync_t1;
   wire       ovf_tx;
   wire       ovf_rx;
   wire       rx_force;
   wire       tmr_run = tmrcfg_r[`USP_TCFG_RUN];
   wire [2:0] tmr_src = tmrcfg_r[2:0];

   usp_sync #(.INIT(1'b1)) u_rx_sync (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .din     (rx_pin),
      .dout    (sync_rx)
   );

   usp_sync #(.INIT(1'b0)) u_t1_sync (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .din     (timer1_external_input),
      .dout    (sync_t1)
   );

   // The external oscillator is sampled; it must run below a quarter of sys_clk.
   usp_sync #(.INIT(1'b0)) u_xo_sync (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .din     (ext_osc_clk),
      .dout    (sync_xo)
   );

   // Timer tick selection from the chosen clock source.
   reg [5:0] presc_r;
   reg [2:0] xo_div_r;
   reg       xo_d_r;
   reg       t1_d_r;
   reg       tick;
   wire      xo_rise = sync_xo & ~xo_d_r;
   wire      xo_wrap = ({1'b0, xo_div_r} == `USP_EXT_DIV - 4'h1);
   wire      t1_fall = ~sync_t1 & t1_d_r;
   reg [5:0] presc_max;

   always @* begin
      case (tmr_src)
         `USP_SRC_DIV12: presc_max = `USP_PRESC_DIV12;
         `USP_SRC_DIV48: presc_max = `USP_PRESC_DIV48;
         default:        presc_max = `USP_PRESC_DIV4;
      endcase
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         presc_r  <= 6'd0;
         xo_div_r <= 3'd0;
         xo_d_r   <= 1'b0;
         t1_d_r   <= 1'b0;
         tick     <= 1'b0;
      end else begin
         xo_d_r <= sync_xo;
         t1_d_r <= sync_t1;
         tick   <= 1'b0;
         if (tmr_src == `USP_SRC_EXT8) begin //R13 R14
            if (xo_rise) begin
               xo_div_r <= xo_wrap ? 3'd0 : xo_div_r + 3'd1;
               tick     <= xo_wrap;
            end
         end else if (tmr_src == `USP_SRC_PIN) begin
            tick <= t1_fall; //R13
         end else if (presc_r >= presc_max - 6'd1) begin
            presc_r <= 6'd0;
            tick    <= 1'b1; //R13
         end else begin
            presc_r <= presc_r + 6'd1;
         end
      end
   end

   // Transmit timer is the low count; the receive copy is reloaded on start.
   usp_reload_cnt #(.WIDTH(CNT_W)) u_tx_cnt ( //R07 R08
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .tick       (tick & tmr_run),
      .force_load (1'b0),
      .reload     (reload_r),
      .ovf        (ovf_tx)
   );

   usp_reload_cnt #(.WIDTH(CNT_W)) u_rx_cnt ( //R08 R10 R11
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .tick       (tick & tmr_run),
      .force_load (rx_force),
      .reload     (reload_r),
      .ovf        (ovf_rx)
   );

   // Divide-by-two of each overflow stream.
   reg tx_half_r;
   reg rx_half_r;
   wire tx_baud = ovf_tx & tx_half_r; //R09
   wire rx_mid  = ovf_rx & ~rx_half_r;

   // Transmitter.
   reg [2:0] tx_st_r;
   reg [9:0] tx_sh_r;
   reg [3:0] tx_cnt_r;
   wire      data_wr;
   wire [7:0] data_wbyte;
   wire      tx_set = (tx_st_r == TX_STOP) && tx_baud;

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_half_r <= 1'b0;
         tx_st_r   <= TX_IDLE;
         tx_sh_r   <= 10'h3ff;
         tx_cnt_r  <= 4'd0;
         tx_pin    <= 1'b1;
      end else begin
         if (ovf_tx)
            tx_half_r <= ~tx_half_r;
         case (tx_st_r)
            TX_IDLE: begin
               tx_pin <= 1'b1;
               if (data_wr) begin //R03
                  tx_sh_r  <= {tb8_r, data_wbyte, 1'b0}; //R15 R16
                  tx_cnt_r <= mode9_r ? `USP_FRAME9_BITS - 4'd1 : `USP_FRAME8_BITS - 4'd1;
                  tx_st_r  <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (tx_baud) begin
                  tx_pin   <= tx_sh_r[0];
                  tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
                  tx_cnt_r <= tx_cnt_r - 4'd1;
                  if (tx_cnt_r == 4'd1)
                     tx_st_r <= TX_STOP; //R18
               end
            end
            TX_STOP: begin
               if (tx_baud) begin
                  tx_pin  <= 1'b1;
                  tx_st_r <= TX_IDLE;
               end
            end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   // Receiver.
   reg [2:0] rx_st_r;
   reg [8:0] rx_sh_r;
   reg [3:0] rx_cnt_r;
   reg       rx_d_r;
   wire      start_edge = (rx_st_r == RX_IDLE) && ren_r && tmr_run && rx_d_r && !sync_rx;
   assign rx_force = start_edge; //R11
   reg       rx_load;
   reg       rx_bit9;
   reg [7:0] rx_byte;

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_half_r <= 1'b0;
         rx_st_r   <= RX_IDLE;
         rx_sh_r   <= 9'h000;
         rx_cnt_r  <= 4'd0;
         rx_d_r    <= 1'b1;
         rx_load   <= 1'b0;
         rx_bit9   <= 1'b0;
         rx_byte   <= 8'h00;
      end else begin
         rx_d_r  <= sync_rx;
         rx_load <= 1'b0;
         if (start_edge)
            rx_half_r <= 1'b0;
         else if (ovf_rx)
            rx_half_r <= ~rx_half_r;
         case (rx_st_r)
            RX_IDLE: begin
               if (start_edge) begin
                  rx_cnt_r <= mode9_r ? `USP_FRAME9_BITS : `USP_FRAME8_BITS; //R01
                  rx_st_r  <= RX_BITS;
               end
            end
            RX_BITS: begin
               if (rx_mid) begin //R19
                  rx_cnt_r <= rx_cnt_r - 4'd1;
                  if (rx_cnt_r == (mode9_r ? `USP_FRAME9_BITS : `USP_FRAME8_BITS)) begin
                     if (sync_rx)
                        rx_st_r <= RX_IDLE;
                  end else if (rx_cnt_r == 4'd1) begin
                     rx_bit9 <= mode9_r ? rx_sh_r[8] : sync_rx; //R16
                     rx_byte <= mode9_r ? rx_sh_r[7:0] : rx_sh_r[8:1]; //R15
                     rx_st_r <= RX_DONE;
                  end else begin
                     rx_sh_r <= {sync_rx, rx_sh_r[8:1]};
                  end
               end
            end
            RX_DONE: begin
               rx_load <= 1'b1; //R02
               rx_st_r <= RX_IDLE;
            end
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end

   wire rx_accept = rx_load && !rdone_r && (!mce_r || rx_bit9); //R17
   wire rx_set    = rx_accept;

   // AXI4-Lite slave.
   wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire wr_ctrl   = wr_go && (aw_addr_r == `USP_OFF_CTRL) && w_strb_r[0];
   wire wr_status = wr_go && (aw_addr_r == `USP_OFF_STATUS) && w_strb_r[0];
   assign data_wr    = wr_go && (aw_addr_r == `USP_OFF_DATA) && w_strb_r[0] &&
                       (tx_st_r == TX_IDLE);
   assign data_wbyte = w_data_r[7:0];
   wire addr_ok_w = (aw_addr_r <= `USP_OFF_MASK) && (aw_addr_r[1:0] == 2'b00);
   wire addr_ok_r = (s_axi_araddr <= `USP_OFF_MASK) && (s_axi_araddr[1:0] == 2'b00);
   wire [7:0] ctrl_rd = {mode9_r, 1'b1, mce_r, ren_r, tb8_r, rb8_r, tdone_r, rdone_r};

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held_r    <= 1'b0;
         aw_addr_r    <= 12'h000;
         w_held_r     <= 1'b0;
         w_data_r     <= 32'h0000_0000;
         w_strb_r     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= 2'b00;
         s_axi_rdata  <= 32'h0000_0000;
         mode9_r      <= CTRL_RST[`USP_CTRL_MODE9];
         mce_r        <= 1'b0;
         ren_r        <= 1'b0;
         tb8_r        <= 1'b0;
         rb8_r        <= 1'b0;
         tdone_r      <= 1'b0;
         rdone_r      <= 1'b0;
         rx_buf_r     <= 8'h00;
         reload_r     <= `USP_RST_RELOAD;
         tmrcfg_r     <= `USP_RST_TMRCFG;
         irq_mask_r   <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_ok_w ? 2'b00 : 2'b10;
            if (w_strb_r[0]) begin
               case (aw_addr_r)
                  `USP_OFF_CTRL: begin
                     mode9_r <= w_data_r[`USP_CTRL_MODE9];
                     mce_r   <= w_data_r[`USP_CTRL_MCE];
                     ren_r   <= w_data_r[`USP_CTRL_REN];
                     tb8_r   <= w_data_r[`USP_CTRL_TB8];
                     rb8_r   <= w_data_r[`USP_CTRL_RB8];
                  end
                  `USP_OFF_RELOAD: reload_r <= w_data_r[7:0];
                  `USP_OFF_TMRCFG: tmrcfg_r <= w_data_r[3:0];
                  `USP_OFF_MASK:   irq_mask_r <= w_data_r[1:0];
                  default: ;
               endcase
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // Flags: hardware set wins over a software clear in the same cycle.
         if (tx_set)
            tdone_r <= 1'b1; //R05 R18
         else if ((wr_ctrl && !w_data_r[`USP_CTRL_TDONE]) ||
                  (wr_status && w_data_r[`USP_CTRL_TDONE]))
            tdone_r <= 1'b0; //R06
         else if (wr_ctrl)
            tdone_r <= 1'b1;
         if (rx_set) begin
            rdone_r  <= 1'b1; //R05
            rx_buf_r <= rx_byte; //R02
            rb8_r    <= rx_bit9; //R16
         end else if ((wr_ctrl && !w_data_r[`USP_CTRL_RDONE]) ||
                      (wr_status && w_data_r[`USP_CTRL_RDONE]))
            rdone_r <= 1'b0; //R06
         else if (wr_ctrl)
            rdone_r <= 1'b1;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_ok_r ? 2'b00 : 2'b10;
            case (s_axi_araddr)
               `USP_OFF_CTRL:   s_axi_rdata <= {24'h000000, ctrl_rd};
               `USP_OFF_DATA:   s_axi_rdata <= {24'h000000, rx_buf_r}; //R04
               `USP_OFF_RELOAD: s_axi_rdata <= {24'h000000, reload_r};
               `USP_OFF_TMRCFG: s_axi_rdata <= {28'h0000000, tmrcfg_r};
               `USP_OFF_STATUS: s_axi_rdata <= {30'h0, tdone_r, rdone_r};
               `USP_OFF_MASK:   s_axi_rdata <= {30'h0, irq_mask_r};
               default:         s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   assign irq = |({tdone_r, rdone_r} & irq_mask_r); //R05
endmodule

// >>> testbench/uart_with_timer_baud_gen_tb.sv
// Self-checking bench for the serial port with timer baud generation.
`timescale 1ns/100ps
module uart_with_timer_baud_gen_tb;
   reg         sys_clk = 1'b0;
   reg         reset_n = 1'b1;
   reg         xo      = 1'b0;
   reg  [1:0]  xc      = 2'h0;
   reg  [11:0] awaddr  = 12'h000;
   reg  [11:0] araddr  = 12'h000;
   reg  [31:0] wdata   = 32'h0;
   reg         awvalid = 1'b0;
   reg         wvalid  = 1'b0;
   reg         bready  = 1'b0;
   reg         arvalid = 1'b0;
   reg         rready  = 1'b0;
   wire        awready, wready, bvalid, arready, rvalid, tx_pin, rx_pin, irq;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   reg  [31:0] rd;
   reg  [1:0]  rs;
   integer     errors = 0;
   integer     total_checks = 0;
   integer     c, k;
   always #25 sys_clk = ~sys_clk;
   // Slow external clock, toggling every third system clock, feeds both external sources.
   always @(posedge sys_clk) begin
      xc <= (xc == 2'h2) ? 2'h0 : xc + 2'h1;
      if (xc == 2'h2) xo <= ~xo;
   end
   usp_uart usp_uart_i (.sys_clk, .reset_n, .ext_osc_clk(xo), .timer1_external_input(xo),
      .rx_pin, .tx_pin, .irq, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   uwtbg_remote uwtbg_remote_i (.sys_clk, .tx_pin, .rx_pin);
   task complete_run;
      begin
         $display("checks %0d errors %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task tmo(input integer n);
      if (n >= 2000) begin
         errors = errors + 1;
         complete_run;
      end
   endtask
   task wr(input [11:0] a, input [31:0] d, input [1:0] er);
      reg ad, wd, dn;
      integer n;
      begin
         awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
         ad = 0; wd = 0; dn = 0; n = 0;
         while (!dn && n < 2000) begin
            @(posedge sys_clk);
            n = n + 1;
            if (ad && wd && bvalid) begin dn = 1; rs = bresp; end
            if (awready && !ad) begin ad = 1; awvalid <= 1'b0; end
            if (wready && !wd) begin wd = 1; wvalid <= 1'b0; end
         end
         tmo(n);
         chk("bresp", rs, er);
      end
   endtask
   task rdr(input [11:0] a, input [1:0] er);
      reg ag, dn;
      integer n;
      begin
         araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
         ag = 0; dn = 0; n = 0;
         while (!dn && n < 2000) begin
            @(posedge sys_clk);
            n = n + 1;
            if (ag && rvalid) begin dn = 1; rd = rdata; rs = rresp; end
            if (arready && !ag) begin ag = 1; arvalid <= 1'b0; end
         end
         tmo(n);
         chk("rresp", rs, er);
      end
   endtask
   task wait_irq;
      for (c = 0; irq !== 1'b1 && c < 2000; c = c + 1) @(posedge sys_clk);
      tmo(c);
   endtask
   task wait_rx(input integer m);
      for (c = 0; uwtbg_remote_i.got_n < m && c < 2000; c = c + 1) @(posedge sys_clk);
      tmo(c);
   endtask
   // Sends one 9-bit frame on the given timer source and times start bit to done flag.
   task src_gap(input [31:0] cfg, input integer lo);
      begin
         wr(12'h010, 32'h2, 2'h0);
         wr(12'h00c, cfg, 2'h0);
         wr(12'h004, 32'h3c, 2'h0);
         for (c = 0; tx_pin !== 1'b0 && c < 2000; c = c + 1) @(posedge sys_clk);
         tmo(c);
         for (c = 0; irq !== 1'b1 && c < 2000; c = c + 1) @(posedge sys_clk);
         chk("source timing", (c >= lo && c <= lo + 4), 32'h1);
      end
   endtask
   initial begin
      reset_n <= 1'b0;
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      for (k = 0; k < 5; k = k + 1) begin
         rdr((k == 0) ? 12'h000 : k * 4 + 4, 2'h0);
         chk("reset value", rd, (k == 0) ? 32'h40 : 32'h0);
      end
      rdr(12'h018, 2'h2);
      chk("unmapped", rd, 32'h0);
      wr(12'h01c, 32'h5, 2'h2);
      // Reload 0xff with the divide-by-4 source gives eight clocks per bit.
      wr(12'h008, 32'hff, 2'h0);
      wr(12'h00c, 32'h08, 2'h0);
      wr(12'h014, 32'h03, 2'h0);
      wr(12'h000, 32'h10, 2'h0);
      wr(12'h004, 32'ha5, 2'h0);
      for (c = 0; tx_pin !== 1'b0 && c < 2000; c = c + 1) @(posedge sys_clk);
      tmo(c);
      for (c = 0; irq !== 1'b1 && c < 2000; c = c + 1) @(posedge sys_clk);
      chk("tdone time", (c >= 70 && c <= 76), 32'h1);
      wait_rx(1);
      chk("tx byte", uwtbg_remote_i.got, 32'ha5);
      rdr(12'h010, 2'h0);
      chk("status tx", rd, 32'h2);
      rdr(12'h000, 2'h0);
      chk("ctrl tx", rd, 32'h52);
      wr(12'h010, 32'h2, 2'h0);
      wr(12'h000, 32'h10, 2'h0);
      chk("irq clear", irq, 32'h0);
      uwtbg_remote_i.send(8'h3c, 1'b0, 1'b0, 1'b1);
      wait_irq;
      rdr(12'h004, 2'h0);
      chk("rx byte", rd, 32'h3c);
      rdr(12'h000, 2'h0);
      chk("ctrl rx", rd, 32'h55);
      fork
         uwtbg_remote_i.send(8'h77, 1'b0, 1'b0, 1'b1);
         wr(12'h004, 32'h99, 2'h0);
      join
      wait_rx(2);
      chk("duplex tx", uwtbg_remote_i.got, 32'h99);
      rdr(12'h004, 2'h0);
      chk("rx held", rd, 32'h3c);
      wr(12'h000, 32'h30, 2'h0);
      wr(12'h010, 32'h3, 2'h0);
      uwtbg_remote_i.send(8'h11, 1'b0, 1'b0, 1'b0);
      rdr(12'h010, 2'h0);
      chk("bad stop", rd, 32'h0);
      uwtbg_remote_i.send(8'h22, 1'b0, 1'b0, 1'b1);
      wait_irq;
      rdr(12'h004, 2'h0);
      chk("good stop", rd, 32'h22);
      wr(12'h000, 32'hb8, 2'h0);
      wr(12'h010, 32'h3, 2'h0);
      uwtbg_remote_i.nine = 1'b1;
      uwtbg_remote_i.send(8'h81, 1'b1, 1'b0, 1'b1);
      rdr(12'h010, 2'h0);
      chk("ninth zero", rd, 32'h0);
      uwtbg_remote_i.send(8'h42, 1'b1, 1'b1, 1'b1);
      wait_irq;
      rdr(12'h000, 2'h0);
      chk("ctrl nine", rd, 32'hfd);
      rdr(12'h004, 2'h0);
      chk("rx nine", rd, 32'h42);
      wr(12'h004, 32'h5a, 2'h0);
      wait_rx(3);
      chk("tx nine", {uwtbg_remote_i.got9, uwtbg_remote_i.got}, 32'h15a);
      wr(12'h014, 32'h0, 2'h0);
      chk("masked", irq, 32'h0);
      wr(12'h014, 32'h2, 2'h0);
      chk("unmasked", irq, 32'h1);
      wr(12'h010, 32'h2, 2'h0);
      rdr(12'h010, 2'h0);
      chk("sticky", rd, 32'h1);
      chk("irq off", irq, 32'h0);
      src_gap(32'h0c, 118);
      src_gap(32'h0b, 958);
      complete_run;
   end
endmodule

// >>> testbench/uwtbg_properties.sv
// Checker that watches the serial port's pins and register bus.
`timescale 1ns/100ps
module uwtbg_properties (
   input wire        sys_clk,
   input wire        reset_n,
   input wire        tx_pin,
   input wire        irq,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   wire rd_go  = s_axi_arvalid && s_axi_arready;
   wire rd_bad = (s_axi_araddr > 12'h014) || (s_axi_araddr[1:0] != 2'h0);
   chk_rd_answer: assert property (rd_go |=> s_axi_rvalid)
      else $error("read answer late");
   chk_rd_slverr: assert property (rd_go && rd_bad |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   chk_rd_okay: assert property (rd_go && !rd_bad |=> s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h0)
      else $error("mapped read wrong");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answering");
   chk_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   chk_tx_idle: assert property (@(posedge sys_clk) disable iff (1'b0) !reset_n |-> tx_pin && !irq)
      else $error("pins not idle in reset");
   cover property (rd_go && rd_bad);
   cover property ($fell(tx_pin));
   cover property ($rose(irq));
endmodule
bind usp_uart uwtbg_properties uwtbg_properties_i (.sys_clk, .reset_n, .tx_pin, .irq,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready);

// >>> testbench/uwtbg_remote.sv
// Remote serial transceiver facing the port's pins.
`timescale 1ns/100ps
module uwtbg_remote #(
   parameter BIT_CYC = 8
) (
   input  wire sys_clk,
   input  wire tx_pin,
   output reg  rx_pin
);
   reg [7:0] got   = 8'h00;
   reg       got9  = 1'b0;
   reg       nine  = 1'b0;
   integer   got_n = 0;
   integer   i;
   integer   j;
   initial rx_pin = 1'b1;
   // Samples each data bit, and the ninth bit when enabled, in the middle of its bit time.
   always begin
      @(negedge tx_pin);
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      for (i = 0; i < 8; i = i + 1) begin
         repeat (BIT_CYC) @(posedge sys_clk);
         got[i] = tx_pin;
      end
      if (nine) begin
         repeat (BIT_CYC) @(posedge sys_clk);
         got9 = tx_pin;
      end
      repeat (BIT_CYC) @(posedge sys_clk);
      got_n = got_n + 1;
   end
   // Sends start, data LSB first, optional ninth bit, stop, then idles high.
   task send(input [7:0] d, input nb, input b9, input sv);
      reg [10:0] f;
      begin
         f = nb ? {sv, b9, d, 1'b0} : {1'b1, sv, d, 1'b0};
         for (j = 0; j < 11; j = j + 1) begin
            rx_pin <= f[j];
            repeat (BIT_CYC) @(posedge sys_clk);
         end
         rx_pin <= 1'b1;
         repeat (2 * BIT_CYC) @(posedge sys_clk);
      end
   endtask
endmodule
